//--- pcf_cfg_top.sv
// function 0 configuration header with command and subsystem loading
`include "pcf_params.svh"

module pcf_cfg_top #(
    // arbitrary neutral identification values
    parameter logic [15:0] MAKER_CODE = 16'h1A2B,
    parameter logic [15:0] PART_CODE  = 16'h3C4D,
    parameter logic [7:0]  REVISION   = 8'h00,
    parameter int          EE_DIV     = `PCF_EE_DIV
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        cfg_req_in,
    input  wire logic        cfg_we_in,
    input  wire logic [7:0]  cfg_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic [31:0]      cfg_rdata_out,
    output logic             cfg_ack_out,
    input  wire logic        addr_perr_in,
    input  wire logic        data_perr_in,
    input  wire logic        perr_seen_in,
    input  wire logic        master_abort_in,
    input  wire logic        target_abort_rcvd_in,
    input  wire logic        target_abort_sig_in,
    input  wire logic        master_req_in,
    output logic             bus_req_out,
    input  wire logic        io_hit_in,
    output logic             io_claim_out,
    input  wire logic        mem_hit_in,
    output logic             mem_claim_out,
    input  wire logic        special_hit_in,
    output logic             special_claim_out,
    output logic             serr_n_out,
    output logic             serr_oe_out,
    output logic             perr_n_out,
    output logic             perr_oe_out,
    input  wire logic        ee_do_in,
    output logic             ee_cs_out,
    output logic             ee_clk_out,
    output logic             ee_di_out,
    output logic             ssid_valid_out
);

    // ----------------------------------------------------------------
    // decode helper
    // ----------------------------------------------------------------
    // map a dword offset to a function specific byte register slot
    function automatic logic [4:0] fs_index(input logic [7:0] addr);
        case (addr)
            `PCF_OFF_MISC:    fs_index = 5'h00;
            `PCF_OFF_CODEC:   fs_index = 5'h01;
            `PCF_OFF_TIMER:   fs_index = 5'h02;
            `PCF_OFF_PLL0:    fs_index = 5'h03;
            `PCF_OFF_PLL1:    fs_index = 5'h04;
            `PCF_OFF_PLL2:    fs_index = 5'h05;
            `PCF_OFF_TEST:    fs_index = 5'h06;
            `PCF_OFF_IRQ0:    fs_index = 5'h07;
            `PCF_OFF_IRQ1:    fs_index = 5'h08;
            `PCF_OFF_IRQ2:    fs_index = 5'h09;
            `PCF_OFF_IRQ3:    fs_index = 5'h0A;
            `PCF_OFF_IRQ4:    fs_index = 5'h0B;
            `PCF_OFF_IRQ5:    fs_index = 5'h0C;
            `PCF_OFF_IRQ6:    fs_index = 5'h0D;
            `PCF_OFF_IRQ7:    fs_index = 5'h0E;
            `PCF_OFF_COMARCH: fs_index = 5'h0F;
            default:          fs_index = `PCF_FS_NONE;
        endcase
    endfunction : fs_index

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    logic [7:0]  addr_dw;
    logic        wr_en;
    logic        rd_en;
    logic [4:0]  wr_idx;
    logic [4:0]  rd_idx;
    logic        hit_cmd;

    // byte address rounded down to its dword
    assign addr_dw = {cfg_addr_in[7:2], 2'b00};
    assign wr_en   = cfg_req_in & cfg_we_in;
    assign rd_en   = cfg_req_in & ~cfg_we_in;
    assign wr_idx  = fs_index(addr_dw);
    assign rd_idx  = fs_index(addr_dw);
    assign hit_cmd = (addr_dw == `PCF_OFF_CMDSTS);

    // ----------------------------------------------------------------
    // command and status unit
    // ----------------------------------------------------------------
    pcf_cmd_if cmd_bus ();

    // feed writes and bus events to the unit
    assign cmd_bus.wr        = wr_en & hit_cmd;
    assign cmd_bus.be        = cfg_be_in;
    assign cmd_bus.wdata     = cfg_wdata_in;
    assign cmd_bus.addr_perr = addr_perr_in;
    assign cmd_bus.data_perr = data_perr_in;
    assign cmd_bus.perr_seen = perr_seen_in;
    assign cmd_bus.mabort    = master_abort_in;
    assign cmd_bus.rtabort   = target_abort_rcvd_in;
    assign cmd_bus.stabort   = target_abort_sig_in;

    pcf_cmd_stat u_cmd (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .bus        (cmd_bus.regs)
    );

    // ----------------------------------------------------------------
    // subsystem code loader
    // ----------------------------------------------------------------
    logic [31:0] ssid_word;
    logic        ssid_done;
    logic        ee_cs;
    logic        ee_clk;
    logic        ee_di;

    pcf_ssid_loader #(
        .DIV  (EE_DIV),
        .CMDW (`PCF_EE_CMD_BITS),
        .DATW (`PCF_EE_DATA_BITS)
    ) u_ssid (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .ee_do_in   (ee_do_in),
        .ee_cs_out  (ee_cs),
        .ee_clk_out (ee_clk),
        .ee_di_out  (ee_di),
        .ssid_out   (ssid_word),
        .done_out   (ssid_done)
    );

    // loader flops go straight to the pins
    assign ee_cs_out      = ee_cs;
    assign ee_clk_out     = ee_clk;
    assign ee_di_out      = ee_di;
    assign ssid_valid_out = ssid_done;

    // ----------------------------------------------------------------
    // function specific byte registers
    // ----------------------------------------------------------------
    logic [7:0] fs_q [`PCF_FS_COUNT];

    // one writable byte per slot, lane 0 only
    genvar gi;
    generate
        for (gi = 0; gi < `PCF_FS_COUNT; gi++) begin : g_fs
            always_ff @(posedge sys_clk_in) begin
                if (rst_in) begin
                    fs_q[gi] <= `PCF_FS_RST;
                end else if (wr_en && cfg_be_in[0] && wr_idx == 5'(gi)) begin
                    fs_q[gi] <= cfg_wdata_in[7:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] rd_fs;
    logic [31:0] id_word;
    logic [31:0] cmd_word;

    // byte register reads, upper lanes reserved zero
    assign rd_fs = (rd_idx == `PCF_FS_NONE) ? 32'h0000_0000
                                            : {24'h00_0000, fs_q[rd_idx]};

    // identity codes are parameters, never writable
    assign id_word  = {PART_CODE, MAKER_CODE};
    // command bits outside the write mask read back zero
    assign cmd_word = {cmd_bus.sts,
                       cmd_bus.cmd};

    // fixed identities, command with read-only zeros, subsystem codes
    always_comb begin
        case (addr_dw)
            `PCF_OFF_ID:     rd_mux = id_word;
            `PCF_OFF_CMDSTS: rd_mux = cmd_word;
            `PCF_OFF_CLASS:  rd_mux = {`PCF_CLASS_CODE, REVISION};
            `PCF_OFF_SUBSYS: rd_mux = ssid_word;
            default:         rd_mux = rd_fs;
        endcase
    end

    // answer one cycle after the request
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cfg_ack_out   <= 1'b0;
            cfg_rdata_out <= 32'h0000_0000;
        end else begin
            cfg_ack_out   <= cfg_req_in;
            cfg_rdata_out <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // bus behaviour gated by the command enables
    // ----------------------------------------------------------------
    logic mast_en;
    logic io_en;

    assign mast_en = cmd_bus.cmd[`PCF_CMD_MAST];
    assign io_en   = cmd_bus.cmd[`PCF_CMD_IO];

    // request, claim and error pin flops
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bus_req_out       <= 1'b0;
            io_claim_out      <= 1'b0;
            mem_claim_out     <= 1'b0;
            special_claim_out <= 1'b0;
            serr_n_out        <= 1'b0;
            serr_oe_out       <= 1'b0;
            perr_n_out        <= 1'b0;
            perr_oe_out       <= 1'b0;
        end else begin
            bus_req_out       <= master_req_in & mast_en;
            io_claim_out      <= io_hit_in & io_en;
            mem_claim_out     <= mem_hit_in & 1'b0;
            special_claim_out <= special_hit_in & 1'b0;
            serr_n_out        <= 1'b0;
            serr_oe_out       <= cmd_bus.serr_oe;
            perr_n_out        <= 1'b0;
            perr_oe_out       <= cmd_bus.perr_oe;
        end
    end

endmodule : pcf_cfg_top

//--- pcf_chk_assertions.sv
// concurrent checks on the configuration header ports
module pcf_chk_assertions (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic cfg_req_in,
    input wire logic cfg_ack_out,
    input wire logic addr_perr_in,
    input wire logic data_perr_in,
    input wire logic master_req_in,
    input wire logic bus_req_out,
    input wire logic mem_claim_out,
    input wire logic special_claim_out,
    input wire logic serr_oe_out,
    input wire logic perr_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // answers, claims and error pins traced back to their causes
    chk_ack_next: assert property (cfg_req_in |=> cfg_ack_out)
        else $error("no ack after request");
    chk_ack_cause: assert property (cfg_ack_out |-> $past(cfg_req_in))
        else $error("ack without request");
    chk_mem_never: assert property (!mem_claim_out)
        else $error("memory cycle claimed");
    chk_spec_never: assert property (!special_claim_out)
        else $error("special cycle claimed");
    chk_master_cause: assert property (
        bus_req_out |-> $past(master_req_in)) else $error("stray bus request");
    chk_perr_cause: assert property (
        perr_oe_out |-> $past(data_perr_in, 2)) else $error("stray perr");
    chk_serr_cause: assert property (
        serr_oe_out |-> $past(addr_perr_in, 2)) else $error("stray serr");
    chk_reset_quiet: assert property (
        $past(rst_in) |-> !(cfg_ack_out || bus_req_out || perr_oe_out))
        else $error("outputs busy after reset");
    cover property (perr_oe_out);
    cover property (serr_oe_out);
    cover property (bus_req_out);
endmodule : pcf_chk_assertions

//--- pcf_cmd_if.sv
// carrier between the header top and the command/status unit
interface pcf_cmd_if;
    logic              wr;
    logic [3:0]        be;
    logic [31:0]       wdata;
    pcf_pkg::pcf_half_t cmd;
    pcf_pkg::pcf_half_t sts;
    logic              addr_perr;
    logic              data_perr;
    logic              perr_seen;
    logic              mabort;
    logic              rtabort;
    logic              stabort;
    logic              serr_oe;
    logic              perr_oe;

    modport ctrl (output wr, be, wdata, addr_perr, data_perr, perr_seen,
                  output mabort, rtabort, stabort,
                  input  cmd, sts, serr_oe, perr_oe);
    modport regs (input  wr, be, wdata, addr_perr, data_perr, perr_seen,
                  input  mabort, rtabort, stabort,
                  output cmd, sts, serr_oe, perr_oe);
endinterface : pcf_cmd_if

//--- pcf_cmd_stat.sv
// command and status halfwords with parity error reporting
`include "pcf_params.svh"

module pcf_cmd_stat (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    pcf_cmd_if.regs   bus
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    pcf_pkg::pcf_half_t cmd_q;
    pcf_pkg::pcf_half_t sts_q;
    logic               serr_oe_q;
    logic               perr_oe_q;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    logic [15:0] cmd_be;
    logic [15:0] cmd_wmask;
    logic [15:0] sts_be;
    logic [15:0] sts_clr;
    logic [15:0] sts_set;
    logic        serr_fire;
    logic        perr_fire;

    // byte lanes expanded to bit masks
    assign cmd_be    = {{8{bus.be[1]}}, {8{bus.be[0]}}};
    assign sts_be    = {{8{bus.be[3]}}, {8{bus.be[2]}}};
    // only the four writable enables take data
    assign cmd_wmask = bus.wr ? (cmd_be & `PCF_CMD_WR_MASK)
                              : 16'h0000;
    // write 1 to clear, sticky bits only
    assign sts_clr   = bus.wr ? (sts_be & bus.wdata[31:16] & `PCF_STS_STICKY)
                              : 16'h0000;

    // error pins fire only when enabled
    assign serr_fire = bus.addr_perr & cmd_q[`PCF_CMD_SERR];
    assign perr_fire = bus.data_perr & cmd_q[`PCF_CMD_PERR];

    // hardware set vector
    always_comb begin
        sts_set = 16'h0000;
        sts_set[`PCF_STS_RPERR]   = bus.addr_perr | bus.data_perr;
        sts_set[`PCF_STS_SSERR]   = serr_fire;
        sts_set[`PCF_STS_SMABORT] = bus.mabort;
        sts_set[`PCF_STS_RTABORT] = bus.rtabort;
        sts_set[`PCF_STS_STABORT] = bus.stabort;
        // masked by the data parity enable
        sts_set[`PCF_STS_SPERR]   = bus.perr_seen
                                    & cmd_q[`PCF_CMD_PERR];
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // command: zero at reset, writable bits only
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cmd_q <= `PCF_CMD_RST;
        end else begin
            cmd_q <= (cmd_q & ~cmd_wmask) | (bus.wdata[15:0] & cmd_wmask);
        end
    end

    // status: a set in the clearing cycle wins
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sts_q <= `PCF_STS_RST;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
        end
    end

    // open-drain error drivers, one cycle per event
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            serr_oe_q <= 1'b0;
            perr_oe_q <= 1'b0;
        end else begin
            serr_oe_q <= serr_fire;
            perr_oe_q <= perr_fire;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bus.cmd     = cmd_q;
    assign bus.sts     = sts_q | `PCF_STS_FIXED;
    assign bus.serr_oe = serr_oe_q;
    assign bus.perr_oe = perr_oe_q;

endmodule : pcf_cmd_stat

//--- pcf_ee_model.sv
// serial configuration memory holding the subsystem codes
module pcf_ee_model #(
    parameter logic [31:0] WORD = 32'h0
) (
    input  wire logic cs_in,
    input  wire logic clk_in,
    input  wire logic di_in,
    output logic      do_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  n   = 4'h0;
    logic [8:0]  cmd = 9'h000;
    logic [31:0] sh  = WORD;
    initial do_out = 1'b1;
    // command bits taken on rising serial clock, msb first
    always @(posedge clk_in)
        if (cs_in && n < 4'h9) {cmd, n} = {cmd[7:0], di_in, n + 4'h1};
    // answer moves on falling clock; otherwise the line toggles
    always @(negedge clk_in)
        if (cs_in && n == 4'h9 && cmd == 9'h180) {do_out, sh} = {sh, 1'b0};
        else do_out = ~do_out;
endmodule : pcf_ee_model

//--- pcf_params.svh
// constants for the function 0 configuration header
// Operation
// - Offset 00h returns a fixed read-only 16-bit maker code.
// - Offset 02h returns a fixed read-only 16-bit part code.
// - Command bits 15:10 read zero; writes to them are ignored.
// - Fast back-to-back master enable, bit 9, is read-only zero.
// - Address parity report enable set: drive SERR# on address errors.
// - Address/data stepping bit 7 is read-only zero.
// - Data parity report enable set: drive PERR# on data parity error.
// - VGA palette snoop enable, bit 5, is read-only zero.
// - Memory write and invalidate enable, bit 4, is read-only zero.
// - Special cycle bit 3 reads zero; all special cycles are ignored.
// - Bus mastering is requested only while bus master enable is 1.
// - Memory space bit 1 reads zero; memory cycles are never claimed.
// - I/O accesses are claimed only while I/O space enable is 1.
// - Subsystem vendor and subsystem codes load serially from memory.
// - Sticky status error flags clear on writing 1; 0 leaves them.
// - Signalled parity error never sets while data parity report is 0.
`ifndef PCF_PARAMS_SVH
`define PCF_PARAMS_SVH

// ----------------------------------------------------------------
// header offsets (byte address of the dword)
// ----------------------------------------------------------------
`define PCF_OFF_ID        8'h00
`define PCF_OFF_CMDSTS    8'h04
`define PCF_OFF_CLASS     8'h08
`define PCF_OFF_SUBSYS    8'h2C
`define PCF_OFF_MISC      8'h58
`define PCF_OFF_CODEC     8'h5C
`define PCF_OFF_TIMER     8'h64
`define PCF_OFF_PLL0      8'h78
`define PCF_OFF_PLL1      8'h7C
`define PCF_OFF_PLL2      8'h80
`define PCF_OFF_TEST      8'h88
`define PCF_OFF_IRQ0      8'hA0
`define PCF_OFF_IRQ1      8'hA4
`define PCF_OFF_IRQ2      8'hA8
`define PCF_OFF_IRQ3      8'hAC
`define PCF_OFF_IRQ4      8'hB0
`define PCF_OFF_IRQ5      8'hB4
`define PCF_OFF_IRQ6      8'hB8
`define PCF_OFF_IRQ7      8'hBC
`define PCF_OFF_COMARCH   8'hC0

// ----------------------------------------------------------------
// function specific byte registers
// ----------------------------------------------------------------
`define PCF_FS_COUNT      19
`define PCF_FS_NONE       5'h1F
`define PCF_FS_RST        8'h00

// ----------------------------------------------------------------
// command field positions and masks
// ----------------------------------------------------------------
`define PCF_CMD_IO        0
`define PCF_CMD_MAST      2
`define PCF_CMD_PERR      6
`define PCF_CMD_SERR      8
`define PCF_CMD_WR_MASK   16'h0145
`define PCF_CMD_RST       16'h0000

// ----------------------------------------------------------------
// status field positions and values
// ----------------------------------------------------------------
`define PCF_STS_RPERR     15
`define PCF_STS_SSERR     14
`define PCF_STS_SMABORT   13
`define PCF_STS_RTABORT   12
`define PCF_STS_STABORT   11
`define PCF_STS_SPERR     8
`define PCF_STS_STICKY    16'hF900
`define PCF_STS_FIXED     16'h0280
`define PCF_STS_RST       16'h0000

// ----------------------------------------------------------------
// class code and serial memory access
// ----------------------------------------------------------------
`define PCF_CLASS_CODE    24'h040100
`define PCF_EE_READ_CMD   9'h180
`define PCF_EE_CMD_BITS   9
`define PCF_EE_DATA_BITS  32
`define PCF_EE_DIV        4

`endif

//--- pcf_pkg.sv
// types shared by the configuration header modules
package pcf_pkg;

    // ----------------------------------------------------------------
    // serial loader states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PCF_LD_IDLE  = 3'h1,
        PCF_LD_SHIFT = 3'h2,
        PCF_LD_DONE  = 3'h4
    } pcf_ld_state_t;

    typedef logic [15:0] pcf_half_t;

endpackage : pcf_pkg

//--- pcf_ssid_loader.sv
// serial memory reader for the subsystem identification codes
`include "pcf_params.svh"

module pcf_ssid_loader #(
    parameter int DIV  = `PCF_EE_DIV,
    parameter int CMDW = `PCF_EE_CMD_BITS,
    parameter int DATW = `PCF_EE_DATA_BITS
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ee_do_in,
    output logic             ee_cs_out,
    output logic             ee_clk_out,
    output logic             ee_di_out,
    output logic [DATW-1:0]  ssid_out,
    output logic             done_out
);

    localparam logic [6:0] TOTAL   = 7'(CMDW + DATW);
    localparam logic [6:0] CMDLEN  = 7'(CMDW);
    localparam logic [7:0] DIVLAST = 8'(DIV - 1);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pcf_pkg::pcf_ld_state_t state_q;
    logic                   do_s1_q;
    logic                   do_s2_q;
    logic [7:0]             div_q;
    logic [6:0]             cnt_q;
    logic [CMDW-1:0]        cmd_q;
    logic [DATW-1:0]        sh_q;
    logic                   tick;
    logic                   in_data;

    // phase tick and read window
    assign tick    = (div_q == DIVLAST);
    assign in_data = (cnt_q >= CMDLEN);

    // pin synchroniser
    always_ff @(posedge sys_clk_in) begin
        do_s1_q <= ee_do_in;
        do_s2_q <= do_s1_q;
    end

    // serial clock phase divider
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // read sequence: command out, then both codes in msb first
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q    <= pcf_pkg::PCF_LD_IDLE;
            ee_cs_out  <= 1'b0;
            ee_clk_out <= 1'b0;
            ee_di_out  <= 1'b0;
            cnt_q      <= 7'h00;
            cmd_q      <= CMDW'(`PCF_EE_READ_CMD);
            sh_q       <= '0;
            ssid_out   <= '0;
            done_out   <= 1'b0;
        end else begin
            case (state_q)
                pcf_pkg::PCF_LD_IDLE: begin
                    ee_cs_out <= 1'b1;
                    ee_di_out <= cmd_q[CMDW-1];
                    cmd_q     <= {cmd_q[CMDW-2:0], 1'b0};
                    state_q   <= pcf_pkg::PCF_LD_SHIFT;
                end
                pcf_pkg::PCF_LD_SHIFT: begin
                    if (tick && !ee_clk_out) begin
                        ee_clk_out <= 1'b1;
                        if (in_data) begin
                            sh_q <= {sh_q[DATW-2:0], do_s2_q};
                        end
                    end else if (tick) begin
                        ee_clk_out <= 1'b0;
                        cnt_q      <= cnt_q + 7'h01;
                        ee_di_out  <= cmd_q[CMDW-1];
                        cmd_q      <= {cmd_q[CMDW-2:0], 1'b0};
                        if (cnt_q + 7'h01 == TOTAL) begin
                            ee_cs_out <= 1'b0;
                            ssid_out  <= sh_q;
                            done_out  <= 1'b1;
                            state_q   <= pcf_pkg::PCF_LD_DONE;
                        end
                    end
                end
                pcf_pkg::PCF_LD_DONE: begin
                    state_q <= pcf_pkg::PCF_LD_DONE;
                end
                default: begin
                    state_q <= pcf_pkg::PCF_LD_IDLE;
                end
            endcase
        end
    end

endmodule : pcf_ssid_loader

//--- pcf_testbench.sv
// self-checking bench for the function 0 configuration header
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // arbitrary identification and subsystem codes
    localparam logic [31:0] IDS = 32'h3C4D1A2B, SSID = 32'h5A5AC3C3;
    logic        sys_clk_in, rst_in, cfg_req_in, cfg_we_in, cfg_ack_out;
    logic [7:0]  cfg_addr_in;
    logic [3:0]  cfg_be_in;
    logic [31:0] cfg_wdata_in, cfg_rdata_out;
    logic [9:0]  ev;
    logic        addr_perr_in, data_perr_in, perr_seen_in, master_abort_in;
    logic        target_abort_rcvd_in, target_abort_sig_in, master_req_in;
    logic        io_hit_in, mem_hit_in, special_hit_in, bus_req_out;
    logic        io_claim_out, mem_claim_out, special_claim_out, ee_do_in;
    logic        serr_oe_out, perr_oe_out, ee_cs_out, ee_clk_out, ee_di_out;
    logic        ssid_valid_out, serr_n_out, perr_n_out;
    int          error_cnt, total_checks;
    // every event input pulses from one vector
    assign {addr_perr_in, data_perr_in, perr_seen_in, master_abort_in,
            target_abort_rcvd_in, target_abort_sig_in, master_req_in,
            io_hit_in, mem_hit_in, special_hit_in} = ev;
    pcf_cfg_top #(.MAKER_CODE(IDS[15:0]), .PART_CODE(IDS[31:16]), .EE_DIV(3))
        dut (.*);
    pcf_ee_model #(.WORD(SSID)) u_ee (.cs_in(ee_cs_out), .clk_in(ee_clk_out),
        .di_in(ee_di_out), .do_out(ee_do_in));
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input logic [32:0] s, input logic [32:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    // one access: request for one edge, ack and data judged while they stand
    task automatic cfg(input logic [44:0] rq, input logic [31:0] e);
        {cfg_we_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = rq;
        cfg_req_in = 1'b1;
        @(posedge sys_clk_in) #1;
        check({cfg_ack_out, cfg_rdata_out}, {1'b1, e});
        cfg_req_in = 1'b0;
        @(posedge sys_clk_in) #1;
    endtask : cfg
    task automatic wr(input logic [43:0] abd);
        cfg({1'b1, abd}, 32'h0);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        cfg({1'b0, a, 36'h0}, e);
    endtask : rdc
    task automatic t_ident;
        rdc(8'h04, 32'h02800000);
        rdc(8'h00, IDS);
        rdc(8'h2C, 32'h0);
        wr({8'h04, 4'hF, 32'hFFFFFFFF});
        rdc(8'h04, 32'h02800145);
        rdc(8'h04, 32'h02800145);
        wr({8'h58, 4'hF, 32'hFFFFFFFF});
        rdc(8'h58, 32'h000000FF);
        rdc(8'h44, 32'h0);
    endtask : t_ident
    task automatic t_events(input logic [15:0] c, input logic [15:0] s);
        wr({8'h04, 4'h3, 16'h0, c});
        ev = 10'h3FF;
        @(posedge sys_clk_in) #1 ev = 10'h0;
        check(33'({bus_req_out, io_claim_out}),
              33'({c[2], c[0]}));
        @(posedge sys_clk_in) #1;
        check(33'({perr_oe_out, serr_oe_out}),
              33'({c[6], c[8]}));
        check(33'({serr_n_out, perr_n_out}), 33'h0);
        rdc(8'h04, {s, c});
        wr({8'h04, 4'hC, 32'h0});
        rdc(8'h04, {s, c});
        wr({8'h04, 4'hC, 32'hFFFF0000});
        rdc(8'h04, {16'h0280, c});
    endtask : t_events
    task automatic t_ssid;
        int n;
        for (n = 0; n < 2000 && ssid_valid_out !== 1'b1; n++)
            @(posedge sys_clk_in) #1;
        check(33'(ssid_valid_out), 33'h1);
        rdc(8'h2C, SSID);
    endtask : t_ssid
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    initial begin
        {rst_in, cfg_req_in, cfg_we_in, cfg_addr_in} = {1'b1, 10'h0};
        {cfg_be_in, cfg_wdata_in, ev} = 46'h0;
        repeat (12) @(posedge sys_clk_in);
        #1 rst_in = 1'b0;
        t_ident();
        t_events(16'h0145, 16'hFB80);
        t_events(16'h0000, 16'hBA80);
        t_ssid();
        end_of_test();
    end
    initial begin
        #200000 error_cnt++;
        end_of_test();
    end
endmodule : testbench
bind pcf_cfg_top pcf_chk_assertions u_chk (
    .sys_clk_in        (sys_clk_in),
    .rst_in            (rst_in),
    .cfg_req_in        (cfg_req_in),
    .cfg_ack_out       (cfg_ack_out),
    .addr_perr_in      (addr_perr_in),
    .data_perr_in      (data_perr_in),
    .master_req_in     (master_req_in),
    .bus_req_out       (bus_req_out),
    .mem_claim_out     (mem_claim_out),
    .special_claim_out (special_claim_out),
    .serr_oe_out       (serr_oe_out),
    .perr_oe_out       (perr_oe_out)
);
